//--- verilog/timer_pkg.sv
package timer_pkg;
    localparam int          NCH          = 5;
    localparam logic [15:0] CNT_RST      = 16'h0000;
    localparam logic [15:0] GEN_RST      = 16'hFFFF;
    localparam logic [15:0] CNT_TOP      = 16'hFFFF;
    localparam logic [15:0] CNT_ONE      = 16'h0001;
    localparam logic [7:0]  STAT_RST     = 8'hC0;
    // word index layout: ch*8 + reg
    localparam logic [2:0]  R_STATUS     = 3'h0;
    localparam logic [2:0]  R_COUNTER    = 3'h1;
    localparam logic [2:0]  R_GEN_A      = 3'h2;
    localparam logic [2:0]  R_GEN_B      = 3'h3;
    localparam logic [2:0]  R_GEN_C      = 3'h4;
    localparam logic [2:0]  R_GEN_D      = 3'h5;
    localparam logic [2:0]  R_CTRL       = 3'h6;
    localparam logic [2:0]  R_IRQEN      = 3'h7;
    localparam logic [2:0]  R_START      = 3'h0;
    localparam logic [2:0]  GLOBAL_CH    = 3'h5;
    // status bit positions
    localparam int          B_DIR        = 7;
    localparam int          B_RES6       = 6;
    localparam int          B_UNF        = 5;
    localparam int          B_OVF        = 4;
    // control register fields
    localparam int          C_CAP0       = 0;
    localparam int          C_DOWN       = 4;
    localparam int          C_UDMODE     = 5;
    localparam int          C_BUFA       = 6;
    localparam int          C_BUFB       = 7;
    localparam logic [7:0]  IRQEN_RST    = 8'h00;
endpackage : timer_pkg

//--- verilog/timer_status_counter_compare.sv
`timescale 1ns/100ps
module timer_status_counter_compare
    import timer_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        standby_i,
    input  wire logic        count_en_i,
    input  wire logic [19:0] capture_i,
    input  wire logic [3:0]  xfer_clear_i,
    input  wire logic        ovf4_xfer_clear_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    output logic [4:0]       irq_o
);
    // ****************************************
    // storage
    // ****************************************
    logic [15:0] cnt_reg   [NCH];
    logic [15:0] gen_reg   [NCH][4];
    logic [7:0]  stat_reg  [NCH];
    logic [7:0]  ctrl_reg  [NCH];
    logic [7:0]  ien_reg   [NCH];
    logic [4:0]  start_reg;
    logic [7:0]  read_snap [NCH];
    logic [19:0] cap_s1_reg;
    logic [19:0] cap_s2_reg;
    logic [19:0] cap_d_reg;
    logic        ce_s1_reg;
    logic        ce_s2_reg;
    logic        init;
    logic        req;
    logic [2:0]  a_ch;
    logic [2:0]  a_rg;
    logic [31:0] ch_rd     [NCH];
    logic [31:0] rd_next;

    assign init = rst_i | standby_i;
    assign req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign a_ch = wb_adr_i[7:5];
    assign a_rg = wb_adr_i[4:2];

    // channel feature lookups
    function automatic logic has_cd(input int ch);
        return (ch == 0) || (ch == 3) || (ch == 4);
    endfunction : has_cd

    function automatic logic can_down(input int ch, input logic [7:0] ctl);
        if (ch == 0) begin
            return 1'b0;
        end
        return ctl[C_UDMODE];
    endfunction : can_down

    function automatic logic [7:0] stat_view(input int ch, input logic [7:0] s);
        logic [7:0] v;
        v = s;
        v[B_RES6] = 1'b1;
        if (ch == 0) begin
            v[B_DIR] = 1'b1;
        end
        if (!((ch == 1) || (ch == 2))) begin
            v[B_UNF] = 1'b0;
        end
        if (!has_cd(ch)) begin
            v[3:2] = 2'b00;
        end
        return v;
    endfunction : stat_view

    // zero-extended view of a 16-bit register
    function automatic logic [31:0] word16(input logic [15:0] w);
        return {16'h0000, w};
    endfunction : word16

    // a flag holds unless a software or transfer clear hits it
    function automatic logic keep_flag(input logic f, input logic sw, input logic hw);
        return f & ~sw & ~hw;
    endfunction : keep_flag

    // ****************************************
    // pin synchronisers
    // ****************************************
    // capture pins: two stages, then one more for the edge
    always_ff @(posedge clk_i) begin
        cap_s1_reg <= capture_i;
        cap_s2_reg <= cap_s1_reg;
        cap_d_reg  <= cap_s2_reg;
    end

    // count enable pin: two stages
    always_ff @(posedge clk_i) begin
        ce_s1_reg  <= count_en_i;
        ce_s2_reg  <= ce_s1_reg;
    end

    // ****************************************
    // per-channel counter, general regs, flags
    // ****************************************
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        logic        hit_ch;
        logic        sel_word;
        logic        sel_byte;
        logic [3:0]  nreg;
        logic        cpl_mode;
        logic        down;
        logic        tick;
        logic [15:0] cnt_next;
        logic        at_top;
        logic        at_one;
        logic        at_zero;
        logic        ovf_up;
        logic        ovf_cpl;
        logic        ovf_ev;
        logic        unf_ev;
        logic        ovf_hw_clr;
        logic        wr_cnt;
        logic        wr_stat;
        logic        rd_stat;
        logic        wr_ctrl;
        logic        wr_ien;
        logic [7:0]  clr;
        logic [3:0]  gev;
        logic [3:0]  cap_edge;
        logic [7:0]  stat_next;
        logic [7:0]  snap_next;
        logic [31:0] rd_word;

        // this channel's slice of the bus
        assign hit_ch   = req & (a_ch == 3'(c));
        assign sel_word = &wb_sel_i[1:0];
        assign sel_byte = wb_sel_i[0];
        assign nreg     = has_cd(c) ? 4'h4 : 4'h2;

        // count direction and count tick
        assign cpl_mode = can_down(c, ctrl_reg[c]);
        assign down     = cpl_mode & ctrl_reg[c][C_DOWN];
        assign tick     = start_reg[c] & ce_s2_reg;
        assign cnt_next = down ? cnt_reg[c] - CNT_ONE : cnt_reg[c] + CNT_ONE;

        // wrap detection on the value about to step
        assign at_top     = (cnt_reg[c] == CNT_TOP);
        assign at_one     = (cnt_reg[c] == CNT_ONE);
        assign at_zero    = (cnt_reg[c] == CNT_RST);
        assign ovf_up     = !down & at_top;
        assign ovf_cpl    = (c == 4) & down & cpl_mode & at_one;
        assign ovf_ev     = tick & (ovf_up | ovf_cpl);
        assign unf_ev     = tick & down & at_zero;
        assign ovf_hw_clr = (c == 4) & ovf4_xfer_clear_i;

        // register strobes of this channel
        assign wr_cnt  = hit_ch & wb_we_i & (a_rg == R_COUNTER) & sel_word;
        assign wr_stat = hit_ch & wb_we_i & (a_rg == R_STATUS) & sel_byte;
        assign rd_stat = hit_ch & !wb_we_i & (a_rg == R_STATUS);
        assign wr_ctrl = hit_ch & wb_we_i & (a_rg == R_CTRL) & sel_byte;
        assign wr_ien  = hit_ch & wb_we_i & (a_rg == R_IRQEN) & sel_byte;

        // clear only bits written 0 that were read as 1
        assign clr = wr_stat ? (read_snap[c] & ~wb_dat_i[7:0]) : 8'h00;

        // counter: bus write beats the count tick
        always_ff @(posedge clk_i) begin
            if (init) begin
                cnt_reg[c] <= CNT_RST;
            end else if (wr_cnt) begin
                cnt_reg[c] <= wb_dat_i[15:0];
            end else if (tick) begin
                cnt_reg[c] <= cnt_next;
            end
        end

        // general registers: compare, capture, buffer
        for (genvar g = 0; g < 4; g++) begin : g_gen
            logic wr_g;
            logic is_cap;
            logic matched;
            logic buffered;
            logic buf_src;

            // strobes and match of this general register
            assign wr_g     = hit_ch & wb_we_i & (a_rg == R_GEN_A + 3'(g))
                              & sel_word;
            assign is_cap   = ctrl_reg[c][C_CAP0 + g];
            assign matched  = (cnt_reg[c] == gen_reg[c][g]);
            // a buffering C or D raises no flag of its own
            assign buffered = (g >= 2) & ctrl_reg[c][C_BUFA + (g & 1)] & has_cd(c);
            assign buf_src  = (g < 2) & ctrl_reg[c][C_BUFA + (g & 1)] & has_cd(c);
            assign cap_edge[g] = cap_s2_reg[c*4+g] & ~cap_d_reg[c*4+g];
            assign gev[g]   = (g < nreg) & !buffered
                              & (is_cap ? cap_edge[g] : matched);

            // load order: reset, bus write, capture, buffer reload
            always_ff @(posedge clk_i) begin
                if (init) begin
                    gen_reg[c][g] <= GEN_RST;
                end else if (wr_g && (g < nreg)) begin
                    gen_reg[c][g] <= wb_dat_i[15:0];
                end else if (is_cap && gev[g]) begin
                    gen_reg[c][g] <= cnt_reg[c];
                end else if (buf_src && !is_cap && matched) begin
                    gen_reg[c][g] <= gen_reg[c][g | 2];
                end
            end
        end

        // next status, a set event wins over any clear
        always_comb begin
            stat_next        = stat_reg[c];
            stat_next[B_DIR] = ~down;
            stat_next[B_OVF] = ovf_ev
                | keep_flag(stat_reg[c][B_OVF], clr[B_OVF], ovf_hw_clr);
            stat_next[B_UNF] = unf_ev
                | keep_flag(stat_reg[c][B_UNF], clr[B_UNF], 1'b0);
            for (int g = 0; g < 4; g++) begin
                stat_next[g] = gev[g]
                    | keep_flag(stat_reg[c][g], clr[g], xfer_clear_i[g]);
            end
        end

        // status register
        always_ff @(posedge clk_i) begin
            if (init) begin
                stat_reg[c] <= STAT_RST;
            end else begin
                stat_reg[c] <= stat_next;
            end
        end

        // flags software has seen as 1 and that are still set
        always_comb begin
            snap_next = read_snap[c] & stat_reg[c];
            if (rd_stat) begin
                snap_next = stat_view(c, stat_reg[c]);
            end
        end

        // snapshot register
        always_ff @(posedge clk_i) begin
            if (init) begin
                read_snap[c] <= 8'h00;
            end else begin
                read_snap[c] <= snap_next;
            end
        end

        // control register
        always_ff @(posedge clk_i) begin
            if (init) begin
                ctrl_reg[c] <= 8'h00;
            end else if (wr_ctrl) begin
                ctrl_reg[c] <= wb_dat_i[7:0];
            end
        end

        // interrupt enable register
        always_ff @(posedge clk_i) begin
            if (init) begin
                ien_reg[c] <= IRQEN_RST;
            end else if (wr_ien) begin
                ien_reg[c] <= wb_dat_i[7:0];
            end
        end

        // read view of this channel's registers
        always_comb begin
            case (a_rg)
                R_STATUS:  rd_word = {24'h00_0000, stat_view(c, stat_reg[c])};
                R_COUNTER: rd_word = word16(cnt_reg[c]);
                R_GEN_A:   rd_word = word16(gen_reg[c][0]);
                R_GEN_B:   rd_word = word16(gen_reg[c][1]);
                R_GEN_C:   rd_word = has_cd(c) ? word16(gen_reg[c][2]) : 32'h0000_0000;
                R_GEN_D:   rd_word = has_cd(c) ? word16(gen_reg[c][3]) : 32'h0000_0000;
                R_CTRL:    rd_word = {24'h00_0000, ctrl_reg[c]};
                default:   rd_word = {24'h00_0000, ien_reg[c]};
            endcase
        end
        assign ch_rd[c] = rd_word;
    end

    // ****************************************
    // interrupt requests
    // ****************************************
    // one request line per channel, gated by its enable register
    always_ff @(posedge clk_i) begin
        if (init) begin
            irq_o <= 5'h00;
        end else begin
            for (int c = 0; c < NCH; c++) begin
                irq_o[c] <= |(stat_view(c, stat_reg[c]) & ien_reg[c] & 8'h3F);
            end
        end
    end

    // ****************************************
    // start register
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (init) begin
            start_reg <= 5'h00;
        end else if (req && wb_we_i && a_ch == GLOBAL_CH && a_rg == R_START && wb_sel_i[0]) begin
            start_reg <= wb_dat_i[4:0];
        end
    end

    // ****************************************
    // wishbone read and acknowledge
    // ****************************************
    // read mux over the channels and the start register
    always_comb begin
        rd_next = 32'h0000_0000;
        if (a_ch == GLOBAL_CH && a_rg == R_START) begin
            rd_next = {27'h000_0000, start_reg};
        end
        for (int c = 0; c < NCH; c++) begin
            if (a_ch == 3'(c)) begin
                rd_next = ch_rd[c];
            end
        end
    end

    // acknowledge one cycle after a taken request, data with it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req;
            if (req && !wb_we_i) begin
                wb_dat_o <= rd_next;
            end else begin
                wb_dat_o <= 32'h0000_0000;
            end
        end
    end
endmodule : timer_status_counter_compare

//--- dv/timer_status_monitor.sv
`timescale 1ns/100ps
// ********************************
// bus answer and status read checks
// ********************************
module timer_status_monitor (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        standby_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_o,
    input  wire logic        wb_ack_o,
    input  wire logic [4:0]  irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // read answer and status address decode
    wire logic rd_ack = wb_ack_o && !wb_we_i;
    wire logic st_adr = (wb_adr_i[4:0] == 5'h00) && (wb_adr_i < 8'hA0);
    AST_ACK_LAT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack not one cycle after request");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_NO_STRAY: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    AST_RST_OUT: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o && irq_o == 5'h00)
        else $error("outputs not cleared by reset");
    AST_STBY_IRQ: assert property (standby_i ##1 standby_i |=> irq_o == 5'h00)
        else $error("irq survives standby");
    AST_RES6: assert property (rd_ack && st_adr |-> wb_dat_o[6] && wb_dat_o[31:8] == 24'h000000)
        else $error("status bit 6 not one");
    AST_CH0_DIR: assert property (rd_ack && wb_adr_i == 8'h00 |-> wb_dat_o[7])
        else $error("channel 0 direction bit not one");
    AST_UNF_RSVD: assert property (rd_ack && wb_adr_i inside {8'h00, 8'h60, 8'h80} |-> !wb_dat_o[5])
        else $error("reserved underflow bit set");
    AST_CD_RSVD: assert property (rd_ack && wb_adr_i inside {8'h20, 8'h40} |-> wb_dat_o[3:2] == 2'h0)
        else $error("reserved flag c or d set");
    AST_WIDE: assert property (rd_ack && wb_adr_i >= 8'hA4 |-> wb_dat_o == 32'h00000000)
        else $error("unmapped read not zero");
endmodule : timer_status_monitor
bind timer_status_counter_compare timer_status_monitor u_timer_status_monitor (
    .clk_i(clk_i), .rst_i(rst_i), .standby_i(standby_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .irq_o(irq_o));

//--- dv/testbench.sv
`timescale 1ns/100ps
module testbench;
    logic        clk_i, rst_i, standby_i, count_en_i, ovf4_xfer_clear_i;
    logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [19:0] capture_i;
    logic [3:0]  xfer_clear_i, wb_sel_i;
    logic [7:0]  wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic [4:0]  irq_o;
    int          mismatches, compares;
    timer_status_counter_compare u_timer_status_counter_compare (
        .clk_i(clk_i), .rst_i(rst_i), .standby_i(standby_i), .count_en_i(count_en_i),
        .capture_i(capture_i), .xfer_clear_i(xfer_clear_i),
        .ovf4_xfer_clear_i(ovf4_xfer_clear_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o));
    // 40 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    task automatic wrap_up();
        if (mismatches == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // one classic cycle, held until ack is sampled
    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [31:0] q);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= s;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (wb_ack_o === 1'b1) begin
            q = wb_dat_o;
            wb_cyc_i <= 1'b0;
            wb_stb_i <= 1'b0;
        end else begin
            mismatches++;
            $display("BAD %0t no ack", $time);
            wrap_up();
        end
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, 4'hF, q);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h00000000, 4'hF, q);
        chk(q, e);
    endtask : rdc
    // ********************************
    // scenarios
    // ********************************
    task automatic t_reset();
        for (int ch = 0; ch < 5; ch++) begin
            rdc(8'(ch * 32), 32'h000000C0);
            rdc(8'(ch * 32 + 4), 32'h00000000);
            rdc(8'(ch * 32 + 8), 32'h0000FFFF);
        end
        wr(8'hC4, 32'h0000FFFF);
        rdc(8'hC4, 32'h00000000);
    endtask : t_reset
    task automatic t_access();
        logic [31:0] q;
        wr(8'h24, 32'h00001234);
        bus(1'b1, 8'h24, 32'h0000FFFF, 4'h1, q);
        rdc(8'h24, 32'h00001234);
        wr(8'h2C, 32'h0000ABCD);
        rdc(8'h2C, 32'h0000ABCD);
    endtask : t_access
    task automatic t_wrap();
        wr(8'h04, 32'h0000FFFE);
        wr(8'h84, 32'h0000FFFE);
        wr(8'h24, 32'h00000001);
        wr(8'h38, 32'h00000030);
        wr(8'h1C, 32'h00000010);
        wr(8'hA0, 32'h00000013);
        repeat (10) @(posedge clk_i);
        wr(8'hA0, 32'h00000000);
        rdc(8'h00, 32'h000000DF);
        rdc(8'h20, 32'h00000061);
        chk({27'h0000000, irq_o}, 32'h00000001);
        wr(8'h00, 32'h000000FF);
        rdc(8'h00, 32'h000000DF);
        wr(8'h00, 32'h000000C0);
        rdc(8'h00, 32'h000000C0);
        chk({27'h0000000, irq_o}, 32'h00000000);
        rdc(8'h80, 32'h000000DF);
        ovf4_xfer_clear_i <= 1'b1;
        @(posedge clk_i);
        ovf4_xfer_clear_i <= 1'b0;
        rdc(8'h80, 32'h000000CF);
        xfer_clear_i <= 4'hF;
        @(posedge clk_i);
        xfer_clear_i <= 4'h0;
        rdc(8'h80, 32'h000000C0);
    endtask : t_wrap
    task automatic t_capture();
        wr(8'h64, 32'h00005A5A);
        wr(8'h78, 32'h00000001);
        capture_i[12] <= 1'b1;
        repeat (4) @(posedge clk_i);
        capture_i[12] <= 1'b0;
        rdc(8'h68, 32'h00005A5A);
        rdc(8'h60, 32'h000000C1);
        xfer_clear_i <= 4'h1;
        @(posedge clk_i);
        xfer_clear_i <= 4'h0;
        rdc(8'h60, 32'h000000C0);
    endtask : t_capture
    task automatic t_extra();
        logic [31:0] q;
        bus(1'b1, 8'h48, 32'h00001234, 4'h1, q);
        rdc(8'h48, 32'h0000FFFF);
        wr(8'h48, 32'h00000000);
        rdc(8'h40, 32'h000000C1);
        wr(8'h40, 32'h000000C0);
        rdc(8'h40, 32'h000000C1);
        wr(8'h48, 32'h0000FFFF);
        rdc(8'h40, 32'h000000C1);
        wr(8'h40, 32'h000000C0);
        rdc(8'h40, 32'h000000C0);
        wr(8'h04, 32'h00000100);
        wr(8'h10, 32'h00001234);
        wr(8'h18, 32'h00000040);
        wr(8'h08, 32'h00000100);
        rdc(8'h08, 32'h00001234);
        wr(8'h18, 32'h00000000);
        wr(8'h98, 32'h00000030);
        wr(8'h84, 32'h00000003);
        wr(8'hA0, 32'h00000010);
        wr(8'hA0, 32'h00000000);
        rdc(8'h84, 32'h00000000);
        rdc(8'h80, 32'h00000050);
    endtask : t_extra
    task automatic t_standby();
        standby_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        standby_i <= 1'b0;
        rdc(8'h24, 32'h00000000);
        rdc(8'h2C, 32'h0000FFFF);
        rdc(8'h20, 32'h000000C0);
    endtask : t_standby
    // reset, then the scenarios in turn
    initial begin
        {rst_i, standby_i, count_en_i, ovf4_xfer_clear_i} = 4'h8;
        {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
        {capture_i, xfer_clear_i, wb_sel_i, wb_adr_i, wb_dat_i} = 68'h0;
        mismatches = 0;
        compares = 0;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        count_en_i <= 1'b1;
        t_reset();
        t_access();
        t_wrap();
        t_capture();
        t_extra();
        t_standby();
        wrap_up();
    end
endmodule : testbench
